// ### src/scu_ctrl.sv
// Purpose: Sequencer that feeds the CRC unit and appends its check bits.
// Assumes: AHB-Lite single word transfers; zero wait states; response always OKAY.
// Notes: A message of up to 32 bits is sent MSB first from MSG.
`timescale 1ns/100ps

module scu_ctrl
    import scu_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Interrupt
    output logic irq,
    // Serial line carrying data then check bits
    output logic line_out,
    output logic line_valid,
    // Link to the CRC unit
    scu_link_if.ctrl link
);
    localparam logic [3:0] HALF = 4'(`SCU_SHIFT_HALF_CYC);

    scu_ctl_state_t state_q;
    logic [4:0] cfg_q;
    logic [31:0] msg_q;
    logic [5:0] len_q;
    logic [1:0] int_stat_q;
    logic [1:0] int_mask_q;
    logic [15:0] chk_q;
    logic miss_q;
    logic [31:0] sh_q;
    logic [5:0] rem_q;
    logic [5:0] dat_q;
    logic [3:0] cnt_q;
    logic wr_q;
    logic [4:0] addr_q;
    logic [31:0] hrdata_q;
    logic irq_q;
    logic shift_q;
    logic din_q;
    logic gate_q;
    logic clear_q;
    logic preset_n_q;
    logic line_q;
    logic lvalid_q;

    wire addr_ok = hsel & htrans[1] & hready;
    wire [4:0] a_addr = haddr[4:0];
    wire wr_en = wr_q;
    wire wr_cfg = wr_en && addr_q == `SCU_OFS_CFG;
    wire wr_msg = wr_en && addr_q == `SCU_OFS_MSG;
    wire wr_len = wr_en && addr_q == `SCU_OFS_LEN;
    wire wr_cmd = wr_en && addr_q == `SCU_OFS_CMD;
    wire wr_ist = wr_en && addr_q == `SCU_OFS_INT_STAT;
    wire wr_imk = wr_en && addr_q == `SCU_OFS_INT_MASK;
    wire busy = state_q != SCU_IDLE;
    wire start = wr_cmd && hwdata[`SCU_CMD_START_BIT] && !busy;
    wire is_check = cfg_q[`SCU_CFG_CHECK_BIT];
    wire [5:0] deg = scu_degree(cfg_q[2:0]);
    wire [5:0] len_c = (len_q > `SCU_MAX_LEN) ? `SCU_MAX_LEN : len_q;
    wire [5:0] total = is_check ? len_c : 6'(len_c + deg);
    wire phase_end = cnt_q == HALF - 4'h1;
    wire set_done = state_q == SCU_FIN;
    wire set_err = set_done && is_check && link.mismatch_flag;
    wire [1:0] int_set = {set_err, set_done};
    wire [1:0] int_next = (int_stat_q & ~(wr_ist ? hwdata[1:0] : 2'b00)) | int_set;
    wire [31:0] status = {chk_q, 14'h0000, miss_q, busy};
    wire [31:0] rd_mux = (a_addr == `SCU_OFS_CFG) ? {27'h0, cfg_q} :
                         (a_addr == `SCU_OFS_MSG) ? msg_q :
                         (a_addr == `SCU_OFS_LEN) ? {26'h0, len_q} :
                         (a_addr == `SCU_OFS_STATUS) ? status :
                         (a_addr == `SCU_OFS_INT_STAT) ? {30'h0, int_stat_q} :
                         (a_addr == `SCU_OFS_INT_MASK) ? {30'h0, int_mask_q} : 32'h0000_0000;

    // Bus slave and software registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= 1'b0;
            addr_q <= 5'h00;
            hrdata_q <= 32'h0000_0000;
            cfg_q <= 5'h00;
            msg_q <= 32'h0000_0000;
            len_q <= 6'h00;
            int_stat_q <= 2'b00;
            int_mask_q <= 2'b00;
            irq_q <= 1'b0;
        end else if (ce) begin
            wr_q <= addr_ok & hwrite;
            addr_q <= a_addr;
            if (addr_ok && !hwrite) begin
                hrdata_q <= rd_mux;
            end
            if (wr_cfg && !busy) begin
                cfg_q <= hwdata[4:0];
            end
            if (wr_msg) begin
                msg_q <= hwdata;
            end
            if (wr_len) begin
                len_q <= hwdata[5:0];
            end
            if (wr_imk) begin
                int_mask_q <= hwdata[1:0];
            end
            int_stat_q <= int_next;
            irq_q <= |(int_next & int_mask_q);
        end
    end

    // Bit sequencer: one shift clock period is two half phases of HALF cycles.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= SCU_IDLE;
            sh_q <= 32'h0000_0000;
            rem_q <= 6'h00;
            dat_q <= 6'h00;
            cnt_q <= 4'h0;
            chk_q <= 16'h0000;
            miss_q <= 1'b0;
            shift_q <= 1'b1;
            din_q <= 1'b0;
            gate_q <= 1'b1;
            clear_q <= 1'b0;
            preset_n_q <= 1'b1;
            line_q <= 1'b0;
            lvalid_q <= 1'b0;
        end else if (ce) begin
            lvalid_q <= 1'b0;
            cnt_q <= phase_end ? 4'h0 : cnt_q + 4'h1;
            unique case (state_q)
                SCU_IDLE: begin
                    cnt_q <= 4'h0;
                    if (start) begin
                        clear_q <= !cfg_q[`SCU_CFG_PRESET_BIT];
                        preset_n_q <= !cfg_q[`SCU_CFG_PRESET_BIT];
                        sh_q <= msg_q;
                        rem_q <= total;
                        dat_q <= len_c;
                        chk_q <= 16'h0000;
                        state_q <= SCU_INIT;
                    end
                end
                SCU_INIT: begin
                    clear_q <= 1'b0;
                    preset_n_q <= 1'b1;
                    din_q <= sh_q[31];
                    gate_q <= dat_q != 6'h00;
                    cnt_q <= 4'h0;
                    state_q <= (rem_q == 6'h00) ? SCU_FIN : SCU_HIGH;
                end
                SCU_HIGH: begin
                    if (phase_end) begin
                        line_q <= gate_q ? din_q : link.data_out;
                        lvalid_q <= 1'b1;
                        if (!gate_q) begin
                            chk_q <= {chk_q[14:0], link.data_out};
                        end
                        shift_q <= 1'b0;
                        state_q <= SCU_LOW;
                    end
                end
                SCU_LOW: begin
                    if (phase_end) begin
                        shift_q <= 1'b1;
                        rem_q <= rem_q - 6'h01;
                        dat_q <= (dat_q != 6'h00) ? dat_q - 6'h01 : 6'h00;
                        sh_q <= {sh_q[30:0], 1'b0};
                        din_q <= (dat_q > 6'h01) ? sh_q[30] : 1'b0;
                        gate_q <= dat_q > 6'h01;
                        state_q <= (rem_q == 6'h01) ? SCU_FIN : SCU_HIGH;
                    end
                end
                SCU_FIN: begin
                    miss_q <= link.mismatch_flag;
                    gate_q <= 1'b1;
                    state_q <= SCU_IDLE;
                end
                default: state_q <= SCU_IDLE;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign irq = irq_q;
    assign line_out = line_q;
    assign line_valid = lvalid_q;
    assign link.shift_clock_n = shift_q;
    assign link.data_in = din_q;
    assign link.checkword_gate = gate_q;
    assign link.clear_all = clear_q;
    assign link.preset_n = preset_n_q;
    assign link.poly_select = cfg_q[2:0];
endmodule

// ### pkg/scu_params.svh
// Purpose: Constants shared by the serial CRC unit and its controller.
// Assumes: One 100 MHz system clock.
// Notes: Offsets are byte addresses of the controller's AHB-Lite registers.
`ifndef SCU_PARAMS_SVH
`define SCU_PARAMS_SVH

`define SCU_CLK_PERIOD_NS 10
`define SCU_SHIFT_HALF_NS 20
`define SCU_SHIFT_HALF_CYC ((`SCU_SHIFT_HALF_NS + `SCU_CLK_PERIOD_NS - 1) / `SCU_CLK_PERIOD_NS)

`define SCU_SEL_CRC16 3'h0
`define SCU_SEL_CRC16R 3'h1
`define SCU_SEL_P16B 3'h2
`define SCU_SEL_CRC12 3'h3
`define SCU_SEL_P8 3'h4
`define SCU_SEL_LRC8 3'h5
`define SCU_SEL_CCITT 3'h6
`define SCU_SEL_CCITTR 3'h7

`define SCU_TAP_CRC16 16'h8005
`define SCU_TAP_CRC16R 16'h4001
`define SCU_TAP_P16B 16'hA097
`define SCU_TAP_CRC12 16'h80F0
`define SCU_TAP_P8 16'hB300
`define SCU_TAP_LRC8 16'h0100
`define SCU_TAP_CCITT 16'h1021
`define SCU_TAP_CCITTR 16'h0811

`define SCU_PRESET_16 16'hFFFF
`define SCU_PRESET_12 16'hFFF0
`define SCU_PRESET_8 16'hFF00

`define SCU_DEG_16 6'h10
`define SCU_DEG_12 6'h0C
`define SCU_DEG_8 6'h08

`define SCU_OFS_CFG 5'h00
`define SCU_OFS_MSG 5'h04
`define SCU_OFS_LEN 5'h08
`define SCU_OFS_CMD 5'h0C
`define SCU_OFS_STATUS 5'h10
`define SCU_OFS_INT_STAT 5'h14
`define SCU_OFS_INT_MASK 5'h18

`define SCU_CFG_SEL_LSB 0
`define SCU_CFG_CHECK_BIT 3
`define SCU_CFG_PRESET_BIT 4
`define SCU_CMD_START_BIT 0
`define SCU_ST_BUSY_BIT 0
`define SCU_ST_MISS_BIT 1
`define SCU_ST_CHK_LSB 16
`define SCU_INT_DONE_BIT 0
`define SCU_INT_ERR_BIT 1
`define SCU_MAX_LEN 6'h20

`endif

// ### pkg/scu_pkg.sv
// Purpose: Types and shared decoding for the serial CRC unit.
// Assumes: scu_params.svh supplies the numeric constants.
// Notes: Polynomial degree is needed by both ends.
`include "scu_params.svh"

package scu_pkg;
    typedef logic [2:0] scu_sel_t;
    typedef enum logic [2:0] {
        SCU_IDLE,
        SCU_INIT,
        SCU_HIGH,
        SCU_LOW,
        SCU_FIN
    } scu_ctl_state_t;

    // Degree of the generator chosen by a select code.
    function automatic logic [5:0] scu_degree(input scu_sel_t sel);
        logic [5:0] deg;
        deg = `SCU_DEG_16;
        if (sel == `SCU_SEL_CRC12) begin
            deg = `SCU_DEG_12;
        end else if (sel == `SCU_SEL_P8 || sel == `SCU_SEL_LRC8) begin
            deg = `SCU_DEG_8;
        end
        return deg;
    endfunction
endpackage

// ### pkg/scu_link_if.sv
// Purpose: Pins between the CRC unit and its sequencing controller.
// Assumes: Every pin is synchronous to the common clock.
// Notes: The shift clock idles high; the unit acts on its falling edge.
`timescale 1ns/100ps

interface scu_link_if;
    import scu_pkg::*;
    logic shift_clock_n;
    logic data_in;
    logic checkword_gate;
    logic clear_all;
    logic preset_n;
    scu_sel_t poly_select;
    logic data_out;
    logic mismatch_flag;

    modport device (
        input shift_clock_n,
        input data_in,
        input checkword_gate,
        input clear_all,
        input preset_n,
        input poly_select,
        output data_out,
        output mismatch_flag
    );

    modport ctrl (
        output shift_clock_n,
        output data_in,
        output checkword_gate,
        output clear_all,
        output preset_n,
        output poly_select,
        input data_out,
        input mismatch_flag
    );
endinterface

// ### src/scu_device.sv
// Purpose: Serial CRC generator and checker with eight selectable polynomials.
// Assumes: Link pins are synchronous to clk; the shift clock is sampled, not used as a clock.
// Notes: Short polynomials sit in the top bits of the 16-bit register.
`timescale 1ns/100ps

module scu_device
    import scu_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Link to the controller
    scu_link_if.device link,
    // Observation
    output logic [15:0] crc_value
);
    // Feedback tap mask of each generator, aligned to the top of the register.
    function automatic logic [15:0] scu_taps(input scu_sel_t sel);
        logic [15:0] t;
        t = `SCU_TAP_CRC16;
        unique case (sel)
            `SCU_SEL_CRC16: t = `SCU_TAP_CRC16;
            `SCU_SEL_CRC16R: t = `SCU_TAP_CRC16R;
            `SCU_SEL_P16B: t = `SCU_TAP_P16B;
            `SCU_SEL_CRC12: t = `SCU_TAP_CRC12;
            `SCU_SEL_P8: t = `SCU_TAP_P8;
            `SCU_SEL_LRC8: t = `SCU_TAP_LRC8;
            `SCU_SEL_CCITT: t = `SCU_TAP_CCITT;
            `SCU_SEL_CCITTR: t = `SCU_TAP_CCITTR;
        endcase
        return t;
    endfunction

    // Value loaded by a preset: only the bits that the chosen degree uses.
    function automatic logic [15:0] scu_preset(input scu_sel_t sel);
        logic [15:0] p;
        logic [5:0] deg;
        deg = scu_degree(sel);
        p = `SCU_PRESET_16;
        if (deg == `SCU_DEG_12) begin
            p = `SCU_PRESET_12;
        end else if (deg == `SCU_DEG_8) begin
            p = `SCU_PRESET_8;
        end
        return p;
    endfunction

    logic [15:0] crc_q;
    logic [15:0] crc_d;
    logic clk_prev_q;
    logic err_q;
    logic err_d;

    // The shift clock idles high, so a high-to-low change is one per bit.
    wire shift_fall = clk_prev_q & ~link.shift_clock_n;
    wire [15:0] taps = scu_taps(link.poly_select);
    wire [15:0] preset_val = scu_preset(link.poly_select);
    wire feedback = link.data_in ^ crc_q[15];
    wire [15:0] shifted = {crc_q[14:0], 1'b0};
    wire [15:0] gen_next = feedback ? (shifted ^ taps) : shifted;
    // With the gate low the feedback is cut and the register just shifts out.
    wire [15:0] out_next = shifted;
    wire [15:0] step_next = link.checkword_gate ? gen_next : out_next;

    // Clear beats preset; both act in the cycle they are seen, edge or not.
    always_comb begin
        crc_d = crc_q;
        if (link.clear_all) begin
            crc_d = 16'h0000;
        end else if (!link.preset_n) begin
            crc_d = preset_val;
        end else if (shift_fall) begin
            crc_d = step_next;
        end
    end

    // The flag follows the register, so it holds until the next edge, clear or preset.
    assign err_d = |crc_d;

    always_ff @(posedge clk) begin
        if (rst) begin
            crc_q <= 16'h0000;
            clk_prev_q <= 1'b1;
            err_q <= 1'b0;
        end else if (ce) begin
            crc_q <= crc_d;
            clk_prev_q <= link.shift_clock_n;
            err_q <= err_d;
        end
    end

    assign link.data_out = crc_q[15];
    assign link.mismatch_flag = err_q;
    assign crc_value = crc_q;
endmodule

// ### sim/scu_link_monitor.sv
// Purpose: Concurrent checks on the pins between the CRC unit and its controller.
// Assumes: One clock; rst synchronous, active high.
// Notes: The register is seen only through data_out and mismatch_flag.
`timescale 1ns/100ps
`include "scu_params.svh"

module scu_link_monitor
    import scu_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller to unit
    input wire logic shift_clock_n,
    input wire logic data_in,
    input wire logic checkword_gate,
    input wire logic clear_all,
    input wire logic preset_n,
    input wire scu_sel_t poly_select,
    // Unit to controller
    input wire logic data_out,
    input wire logic mismatch_flag
);
    localparam logic [15:0] TAPS [0:7] = '{`SCU_TAP_CRC16, `SCU_TAP_CRC16R, `SCU_TAP_P16B, `SCU_TAP_CRC12,
        `SCU_TAP_P8, `SCU_TAP_LRC8, `SCU_TAP_CCITT, `SCU_TAP_CCITTR};
    wire quiet = preset_n && !clear_all;
    wire feed_msb = data_in && TAPS[poly_select][15];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_fall;
        shift_clock_n ##1 !shift_clock_n;
    endsequence
    sequence s_rise;
        !shift_clock_n ##1 shift_clock_n;
    endsequence

    property p_clear;
        clear_all |=> !data_out && !mismatch_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left register nonzero");
    property p_preset;
        !preset_n && !clear_all |=> data_out && mismatch_flag;
    endproperty
    a_preset: assert property (p_preset) else $error("preset did not set top bit");
    property p_hold;
        !$fell(shift_clock_n) && quiet |=> $stable(data_out) && $stable(mismatch_flag);
    endproperty
    a_hold: assert property (p_hold) else $error("register moved without falling shift clock");
    property p_feed;
        s_fall ##0 (checkword_gate && quiet && !mismatch_flag) |=>
            mismatch_flag == $past(data_in) && data_out == $past(feed_msb);
    endproperty
    a_feed: assert property (p_feed) else $error("feedback taps wrong");
    property p_flag;
        data_out |-> mismatch_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("flag low with register nonzero");
    property p_low;
        s_fall |=> !shift_clock_n;
    endproperty
    a_low: assert property (p_low) else $error("shift clock low phase too short");
    property p_high;
        s_rise |=> shift_clock_n;
    endproperty
    a_high: assert property (p_high) else $error("shift clock high phase too short");
    property p_setup;
        $fell(shift_clock_n) |-> $stable(checkword_gate) && $stable(data_in);
    endproperty
    a_setup: assert property (p_setup) else $error("gate or data moved at the shift");
    property p_init;
        clear_all || !preset_n |=> quiet && shift_clock_n;
    endproperty
    a_init: assert property (p_init) else $error("init pulse overlaps shifting");
endmodule

// ### sim/tb_selectable_serial_crc_unit.sv
// Purpose: Self-checking bench for the CRC unit driven by its controller over AHB-Lite.
// Assumes: Zero wait AHB slave; one 100 MHz clock.
// Notes: Expected check words come from a bit-serial reference in this file.
`timescale 1ns/100ps
`include "scu_params.svh"

module tb_selectable_serial_crc_unit;
    logic clk;
    logic rst;
    logic ce;
    logic hsel;
    logic hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    wire hready;
    wire hresp;
    wire [31:0] hrdata;
    wire irq;
    wire line_out;
    wire line_valid;
    wire [15:0] crc_value;
    int err_count;
    int check_count;
    logic bits_q[$];
    localparam logic [15:0] TAPS [0:7] = '{`SCU_TAP_CRC16, `SCU_TAP_CRC16R, `SCU_TAP_P16B, `SCU_TAP_CRC12,
        `SCU_TAP_P8, `SCU_TAP_LRC8, `SCU_TAP_CCITT, `SCU_TAP_CCITTR};

    scu_link_if link();
    scu_device scu_device_inst(.clk(clk), .rst(rst), .ce(ce), .link(link.device), .crc_value(crc_value));
    scu_ctrl scu_ctrl_inst(.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hrdata(hrdata), .hresp(hresp), .irq(irq), .line_out(line_out), .line_valid(line_valid),
        .link(link.ctrl));
    scu_link_monitor scu_link_monitor_inst(.clk(clk), .rst(rst), .shift_clock_n(link.shift_clock_n),
        .data_in(link.data_in), .checkword_gate(link.checkword_gate), .clear_all(link.clear_all),
        .preset_n(link.preset_n), .poly_select(link.poly_select), .data_out(link.data_out),
        .mismatch_flag(link.mismatch_flag));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (line_valid === 1'b1) begin
            bits_q.push_back(line_out);
        end
    end

    task automatic final_report;
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {27'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        check_word(d, exp);
        check_word({31'h0, hresp}, 32'h0);
    endtask

    task automatic irq_step(input logic [4:0] a, input logic [31:0] v, input logic exp);
        wr(a, v);
        repeat (2) @(posedge clk);
        check_word({31'h0, irq}, {31'h0, exp});
    endtask

    function automatic int deg_of(input logic [2:0] s);
        return (s == 3'h3) ? 12 : (s == 3'h4 || s == 3'h5) ? 8 : 16;
    endfunction

    // Bit-serial division, MSB first, short generators kept in the top bits.
    function automatic logic [15:0] ref_reg(input logic [2:0] s, input logic pre, input logic [31:0] m, input int n);
        logic [15:0] r;
        logic fb;
        r = pre ? (16'hFFFF << (16 - deg_of(s))) : 16'h0000;
        for (int i = 31; i > 31 - n; i--) begin
            fb = m[i] ^ r[15];
            r = {r[14:0], 1'b0} ^ (fb ? TAPS[s] : 16'h0000);
        end
        return r;
    endfunction

    task automatic run(input logic [2:0] s, input logic pre, input logic chk, input logic [31:0] m, input int n);
        logic [31:0] st;
        logic [15:0] r;
        logic [15:0] fin;
        int d;
        int tot;
        d = deg_of(s);
        r = ref_reg(s, pre, m, n);
        fin = chk ? r : 16'h0000;
        tot = chk ? n : n + d;
        wr(`SCU_OFS_CFG, {27'h0, pre, chk, s});
        wr(`SCU_OFS_MSG, m);
        wr(`SCU_OFS_LEN, 32'(n));
        wr(`SCU_OFS_INT_STAT, 32'h3);
        bits_q.delete();
        wr(`SCU_OFS_CMD, 32'h1);
        ahb(1'b0, `SCU_OFS_STATUS, 32'h0, st);
        check_word({31'h0, st[0]}, 32'h1);
        // Configuration and a second start must both be ignored while a frame runs.
        wr(`SCU_OFS_CFG, {27'h0, ~pre, ~chk, ~s});
        wr(`SCU_OFS_CMD, 32'h1);
        while (irq !== 1'b1) @(posedge clk);
        ahb(1'b0, `SCU_OFS_STATUS, 32'h0, st);
        check_word({30'h0, st[1:0]}, {30'h0, fin != 16'h0000, 1'b0});
        if (!chk) check_word({16'h0, st[31:16]}, {16'h0, r >> (16 - d)});
        check_word({16'h0, crc_value}, {16'h0, fin});
        check_word(32'(bits_q.size()), 32'(tot));
        for (int k = 0; k < tot; k++) begin
            check_word({31'h0, bits_q[k]}, {31'h0, (k < n) ? m[31 - k] : r[15 + n - k]});
        end
        rd_chk(`SCU_OFS_INT_STAT, {30'h0, chk && fin != 16'h0000, 1'b1});
        rd_chk(`SCU_OFS_CFG, {27'h0, pre, chk, s});
    endtask

    initial begin
        logic [31:0] m;
        logic [15:0] c;
        int d;
        rst = 1'b1;
        ce = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        err_count = 0;
        check_count = 0;
        void'($urandom(32'h47B6));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`SCU_OFS_STATUS, 32'h0);
        rd_chk(5'h1C, 32'h0);
        // A write presented while the enable is low must be lost.
        ce <= 1'b0;
        wr(`SCU_OFS_MSG, $urandom);
        ce <= 1'b1;
        rd_chk(`SCU_OFS_MSG, 32'h0);
        wr(`SCU_OFS_INT_MASK, 32'h1);
        for (int s = 0; s < 8; s++) begin
            for (int p = 0; p < 2; p++) begin
                run(3'(s), p[0], 1'b0, $urandom, p ? 32 : 1 + $urandom % 31);
            end
            d = deg_of(3'(s));
            m = $urandom;
            c = ref_reg(3'(s), 1'b1, m, 32 - d) >> (16 - d);
            m = ((m >> d) << d) | {16'h0, c};
            run(3'(s), 1'b1, 1'b1, m, 32);
            run(3'(s), 1'b1, 1'b1, m ^ (32'h1 << ($urandom % 32)), 32);
        end
        irq_step(`SCU_OFS_INT_MASK, 32'h0, 1'b0);
        irq_step(`SCU_OFS_INT_MASK, 32'h2, 1'b1);
        irq_step(`SCU_OFS_INT_STAT, 32'h2, 1'b0);
        final_report;
    end

    initial begin
        #300000;
        err_count++;
        final_report;
    end
endmodule
